// file: logic/ccs_core_state.sv
/*
 * core state control: status word, interrupt mask, stack select,
 * reset vector load, flag-setting arithmetic, byte reversal, alignment
 * check and little-endian lane placement. assumes all inputs come from
 * same-clock core logic except nrst, and callers honour busy.
 */
// Notes on behaviour
// - flags n,z,c,v sit in bits 31..28
// - t bit 24; executing with t=0 faults
// - bits 5..0 show active exception number
// - mask set blocks all but nmi, fault
// - mask set by special write or state change
// - thread mode stack from control bit 1
// - handler mode always uses main stack
// - control writes ignored in handler mode
// - return updates control automatically, entry leaves it
// - new stack pointer takes effect after barrier
// - add, sub, mov touch flags only when flag-setting
// - word, half, byte alignment definitions
// - unaligned access raises fatal fault
// - little-endian byte lane placement
// - multiply result truncated to 32 bits
// - multiple transfers step address upward
// - word, halves and signed-half byte reversal
// - reset clears stack select bit
// - reset loads pc and t from vector
`timescale 1ns/1ps
`default_nettype none
module ccs_core_state (
	input  wire logic              mclk,
	input  wire logic              nrst,
	input  wire ccs_pkg::ccs_req_t req,
	input  wire ccs_pkg::ccs_exc_t exc_req,
	input  wire ccs_pkg::ccs_exc_t exc_ret,
	input  wire logic              vec_valid,
	input  wire logic [31:0]       vec_data,
	output var  ccs_pkg::ccs_resp_t resp_reg,
	output var  ccs_pkg::ccs_mem_t  mem_reg,
	output var  logic              vec_req_reg,
	output var  logic [31:0]       pc_reg,
	output var  logic              use_psp_reg,
	output var  logic              exc_ack_reg,
	output var  logic              busy_reg
);
	import ccs_pkg::*;

	////////////////////////////////////////////////////////////////////
	function automatic logic is_aligned(input logic [1:0] lo,
		input ccs_size_t sz);
		is_aligned = (sz == SZ_BYTE) || (sz == SZ_HALF && !lo[0]) ||
			(lo == 2'b00);
	endfunction
	function automatic logic [35:0] place(input logic [1:0] lo,
		input ccs_size_t sz, input logic [31:0] d);
		logic [3:0] ln;
		ln = (sz == SZ_BYTE) ? 4'h1 : (sz == SZ_HALF) ? 4'h3 : 4'hf;
		// lowest address gets the least significant byte
		place = {ln << lo, d << {lo, 3'b000}};
	endfunction

	////////////////////////////////////////////////////////////////////
	// reset release through two flops
	logic [1:0] rst_sync_reg;
	logic       rst_n;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			rst_sync_reg <= 2'b00;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	logic [3:0]  flags_reg, flags_next;
	logic        tstate_reg;
	logic [5:0]  exc_reg, exc_next;
	logic        mask_reg, spsel_reg;
	ccs_state_t  state_reg;
	logic [31:0] maddr_reg;
	logic [4:0]  left_reg;
	logic        run, issue, handler, fault, take, ctrl_wr;
	logic [31:0] result;
	logic [32:0] sum;
	logic [63:0] prod;
	logic [35:0] lane;

	assign run     = (state_reg == ST_RUN);
	assign issue   = run && req.valid;
	assign handler = (exc_reg != EXC_THREAD);
	assign ctrl_wr = issue && tstate_reg && req.op == OP_SPEC_WRITE &&
		req.sreg == SR_CTRL && !handler;
	// configurable exceptions blocked by the mask
	assign take = run && exc_req.valid && (!mask_reg ||
		exc_req.num == EXC_NMI || exc_req.num == EXC_FATAL);
	assign lane = place(req.a[1:0], req.size, req.b);

	////////////////////////////////////////////////////////////////////
	// datapath and flag results of one issued operation
	always_comb begin
		flags_next = flags_reg;
		result     = 32'h0000_0000;
		sum        = 33'h0_0000_0000;
		prod       = req.a * req.b;
		fault      = issue && !tstate_reg;
		case (req.op)
		OP_ADD, OP_SUB: begin
			sum = (req.op == OP_ADD) ?
				{1'b0, req.a} + {1'b0, req.b} :
				{1'b0, req.a} + {1'b0, ~req.b} + 33'h0_0000_0001;
			result = sum[31:0];
			if (req.set_flags)
				flags_next = {sum[31], sum[31:0] == 32'h0000_0000, sum[32],
					(req.a[31] == (req.b[31] ^ (req.op == OP_SUB))) &&
					(sum[31] != req.a[31])};
		end
		OP_MOV: begin
			result = req.b;
			if (req.set_flags) // carry and overflow kept
				flags_next[3:2] = {req.b[31], req.b == 32'h0000_0000};
		end
		OP_MUL: begin
			result = prod[31:0];
			flags_next[3:2] = {prod[31], prod[31:0] == 32'h0000_0000};
		end
		OP_REV_WORD:
			result = {req.b[7:0], req.b[15:8], req.b[23:16], req.b[31:24]};
		OP_REV_HALVES:
			result = {req.b[23:16], req.b[31:24], req.b[7:0], req.b[15:8]};
		OP_REV_SHALF:
			result = {{16{req.b[7]}}, req.b[7:0], req.b[15:8]};
		OP_SPEC_WRITE:
			if (req.sreg == SR_PSW) // only flags writable
				flags_next = req.b[FLAG_N:FLAG_V];
		OP_SPEC_READ:
			case (req.sreg)
			SR_PSW:  result = {flags_reg, 3'b000, tstate_reg, 18'h0_0000,
				exc_reg};
			SR_MASK: result = {31'h0000_0000, mask_reg};
			SR_CTRL: result = {30'h0000_0000, spsel_reg, 1'b0};
			default: result = 32'h0000_0000;
			endcase
		OP_MEM, OP_MULTI:
			if (!is_aligned(req.a[1:0],
				(req.op == OP_MULTI) ? SZ_WORD : req.size))
				fault = issue;
		default: result = 32'h0000_0000;
		endcase
		if (!issue || fault)
			flags_next = flags_reg;
	end

	////////////////////////////////////////////////////////////////////
	// condition flags
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			flags_reg <= 4'h0;
		else
			flags_reg <= flags_next;
	end

	// active exception number: fault beats requests, return last
	always_comb begin
		exc_next = exc_reg;
		if (exc_ret.valid && run)
			exc_next = exc_ret.num;
		if (take)
			exc_next = exc_req.num;
		if (fault)
			exc_next = EXC_FATAL;
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			exc_reg <= EXC_THREAD;
		else
			exc_reg <= exc_next;
	end

	// interrupt mask, both instructions reach it
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			mask_reg <= 1'b0;
		else if (issue && tstate_reg && req.sreg == SR_MASK &&
			(req.op == OP_SPEC_WRITE || req.op == OP_CHG_STATE))
			mask_reg <= req.b[MASK_BIT];
	end

	// stack select: software in thread mode, hardware on return
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			spsel_reg <= 1'b0;
		else if (run && exc_ret.valid && !take && !fault &&
			exc_ret.num == EXC_THREAD)
			spsel_reg <= exc_ret.to_psp;
		else if (ctrl_wr && !fault)
			spsel_reg <= req.b[SPSEL_BIT];
	end

	// the live stack choice moves only at a barrier or an exception
	// boundary, so code between the write and the barrier keeps the old
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			use_psp_reg <= 1'b0;
		else if (exc_next != EXC_THREAD)
			use_psp_reg <= 1'b0;
		else if (exc_ret.valid && run)
			use_psp_reg <= exc_ret.to_psp;
		else if (issue && !fault && req.op == OP_SYNC_BAR)
			use_psp_reg <= spsel_reg;
	end

	////////////////////////////////////////////////////////////////////
	// boot, run and multiple-transfer sequencing
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg   <= ST_BOOT_REQ;
			vec_req_reg <= 1'b0;
			pc_reg      <= 32'h0000_0000;
			tstate_reg  <= 1'b0;
			maddr_reg   <= 32'h0000_0000;
			left_reg    <= 5'h00;
		end else begin
			vec_req_reg <= 1'b0;
			case (state_reg)
			ST_BOOT_REQ: begin
				vec_req_reg <= 1'b1;
				state_reg   <= ST_BOOT_WAIT;
			end
			ST_BOOT_WAIT:
				if (vec_valid) begin
					pc_reg     <= vec_data;
					tstate_reg <= vec_data[0];
					state_reg  <= ST_RUN;
				end
			ST_RUN:
				if (issue && !fault && req.op == OP_MULTI &&
					req.count > COUNT_ONE) begin
					maddr_reg <= req.a + WORD_STEP;
					left_reg  <= req.count - COUNT_ONE;
					state_reg <= ST_MULTI;
				end
			ST_MULTI: begin
				maddr_reg <= maddr_reg + WORD_STEP;
				left_reg  <= left_reg - COUNT_ONE;
				if (left_reg == COUNT_ONE)
					state_reg <= ST_RUN;
			end
			default: state_reg <= ST_BOOT_REQ;
			endcase
		end
	end

	// registered answers, memory strobes and handshake outputs
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			resp_reg    <= '0;
			mem_reg     <= '0;
			exc_ack_reg <= 1'b0;
			busy_reg    <= 1'b1;
		end else begin
			resp_reg    <= {issue, fault, result};
			exc_ack_reg <= take && !fault;
			busy_reg    <= !(state_reg == ST_RUN && !(issue && !fault &&
				req.op == OP_MULTI && req.count > COUNT_ONE)) &&
				!(state_reg == ST_MULTI && left_reg == COUNT_ONE);
			if (state_reg == ST_MULTI)
				mem_reg <= {1'b1, mem_reg.write, 4'hf, maddr_reg,
					32'h0000_0000};
			else if (issue && !fault && req.op == OP_MEM)
				mem_reg <= {1'b1, req.write, lane[35:32], req.a,
					lane[31:0]};
			else if (issue && !fault && req.op == OP_MULTI &&
				req.count != 5'h00)
				mem_reg <= {1'b1, req.write, 4'hf, req.a, 32'h0000_0000};
			else
				mem_reg <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	property p_flags_plain;
		issue && tstate_reg && !req.set_flags &&
		(req.op == OP_ADD || req.op == OP_SUB || req.op == OP_MOV)
		|=> $stable(flags_reg);
	endproperty
	a_flags_plain: assert property (p_flags_plain)
		else $error("plain arithmetic changed the flags");
	property p_add_zero;
		issue && tstate_reg && req.set_flags && req.op == OP_ADD &&
		req.a + req.b == 32'h0000_0000 |=> flags_reg[2];
	endproperty
	a_add_zero: assert property (p_add_zero)
		else $error("zero flag missing after a zero sum");
	property p_tstate_fault;
		issue && !tstate_reg |=> resp_reg.fault && exc_reg == EXC_FATAL;
	endproperty
	a_tstate_fault: assert property (p_tstate_fault)
		else $error("no fatal fault with t bit clear");
	property p_unaligned;
		issue && tstate_reg && req.op == OP_MEM && req.size == SZ_WORD &&
		req.a[1:0] != 2'b00 |=> resp_reg.fault && !mem_reg.valid;
	endproperty
	a_unaligned: assert property (p_unaligned)
		else $error("unaligned word access not faulted");
	property p_masked;
		mask_reg && exc_req.valid && exc_req.num >= EXC_SVC
		|=> !exc_ack_reg;
	endproperty
	a_masked: assert property (p_masked)
		else $error("masked exception was accepted");
	property p_handler_main;
		exc_reg != EXC_THREAD |-> !use_psp_reg;
	endproperty
	a_handler_main: assert property (p_handler_main)
		else $error("process stack in use in handler mode");
	property p_ctrl_ignored;
		issue && handler && req.op == OP_SPEC_WRITE &&
		req.sreg == SR_CTRL && !exc_ret.valid |=> $stable(spsel_reg);
	endproperty
	a_ctrl_ignored: assert property (p_ctrl_ignored)
		else $error("control written in handler mode");
	sequence s_sel_write;
		issue && tstate_reg && !handler && !exc_req.valid &&
		req.op == OP_SPEC_WRITE && req.sreg == SR_CTRL;
	endsequence
	sequence s_barrier;
		issue && tstate_reg && !handler && req.op == OP_SYNC_BAR &&
		!exc_req.valid && !exc_ret.valid;
	endsequence
	// a gap cycle between write and barrier is legal software
	property p_barrier;
		s_sel_write ##[1:2] s_barrier |=> use_psp_reg == spsel_reg;
	endproperty
	a_barrier: assert property (p_barrier)
		else $error("barrier did not apply new stack choice");
	property p_multi_step;
		state_reg == ST_MULTI |=> mem_reg.addr == $past(maddr_reg) &&
		mem_reg.lanes == 4'hf;
	endproperty
	a_multi_step: assert property (p_multi_step)
		else $error("multiple transfer address not stepping");
	property p_mul;
		issue && tstate_reg && req.op == OP_MUL
		|=> resp_reg.result == $past(prod[31:0]);
	endproperty
	a_mul: assert property (p_mul)
		else $error("multiply result not truncated product");
	property p_boot;
		state_reg == ST_BOOT_WAIT && vec_valid
		|=> pc_reg == $past(vec_data) && tstate_reg == $past(vec_data[0])
		&& !spsel_reg;
	endproperty
	a_boot: assert property (p_boot)
		else $error("reset vector not loaded");
endmodule // ccs_core_state
`default_nettype wire

// file: pkg/ccs_pkg.sv
/*
 * shared constants, field positions and carriers for the core state
 * control block. assumes a single core clock and same-clock neighbours.
 */
`default_nettype none
package ccs_pkg;
	// status word, control and mask field positions
	localparam int FLAG_N     = 31;
	localparam int FLAG_Z     = 30;
	localparam int FLAG_C     = 29;
	localparam int FLAG_V     = 28;
	localparam int TSTATE_BIT = 24;
	localparam int EXC_MSB    = 5;
	localparam int SPSEL_BIT  = 1;
	localparam int MASK_BIT   = 0;
	// active exception numbers
	localparam logic [5:0] EXC_THREAD    = 6'h00;
	localparam logic [5:0] EXC_NMI       = 6'h02;
	localparam logic [5:0] EXC_FATAL     = 6'h03;
	localparam logic [5:0] EXC_SVC       = 6'h0b;
	localparam logic [5:0] EXC_PENDED_SERVICE_EXCEPTION    = 6'h0e;
	localparam logic [5:0] EXC_TICK      = 6'h0f;
	localparam logic [5:0] EXC_FIRST_EXT = 6'h10;
	localparam logic [31:0] RESET_VECTOR_ADDR = 32'h0000_0004;
	localparam logic [31:0] WORD_STEP         = 32'h0000_0004;
	localparam logic [4:0]  COUNT_ONE         = 5'h01;

	typedef enum logic [3:0] {
		OP_NOP        = 4'b0000,
		OP_ADD        = 4'b0001,
		OP_SUB        = 4'b0010,
		OP_MOV        = 4'b0011,
		OP_MUL        = 4'b0100,
		OP_REV_WORD   = 4'b0101,
		OP_REV_HALVES = 4'b0110,
		OP_REV_SHALF  = 4'b0111,
		OP_SPEC_WRITE = 4'b1000,
		OP_SPEC_READ  = 4'b1001,
		OP_CHG_STATE  = 4'b1010,
		OP_SYNC_BAR   = 4'b1011,
		OP_MEM        = 4'b1100,
		OP_MULTI      = 4'b1101
	} ccs_op_t;
	typedef enum logic [1:0] {
		SR_PSW = 2'b00, SR_MASK = 2'b01, SR_CTRL = 2'b10
	} ccs_sreg_t;
	typedef enum logic [1:0] {
		SZ_BYTE = 2'b00, SZ_HALF = 2'b01, SZ_WORD = 2'b10
	} ccs_size_t;
	typedef enum logic [1:0] {
		ST_BOOT_REQ = 2'b00, ST_BOOT_WAIT = 2'b01,
		ST_RUN = 2'b10, ST_MULTI = 2'b11
	} ccs_state_t;

	typedef struct packed {
		logic        valid;
		ccs_op_t     op;
		logic        set_flags;
		ccs_sreg_t   sreg;
		ccs_size_t   size;
		logic        write;
		logic [4:0]  count;
		logic [31:0] a;
		logic [31:0] b;
	} ccs_req_t;
	typedef struct packed {
		logic        valid;
		logic        fault;
		logic [31:0] result;
	} ccs_resp_t;
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [3:0]  lanes;
		logic [31:0] addr;
		logic [31:0] wdata;
	} ccs_mem_t;
	typedef struct packed {
		logic       valid;
		logic       to_psp;
		logic [5:0] num;
	} ccs_exc_t;
endpackage
`default_nettype wire

// file: test/test_cpu_core_state_control.sv
/*
 * self-checking bench for the core state control block: boot, flags,
 * arithmetic, memory lanes, multi-transfers, stack select, exceptions.
 * assumes the design package and the core state module are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module test_cpu_core_state_control;
	import ccs_pkg::*;
	logic        mclk;
	logic        nrst;
	ccs_req_t    req;
	ccs_exc_t    exc_req;
	ccs_exc_t    exc_ret;
	logic        vec_valid;
	logic [31:0] vec_data;
	ccs_resp_t   resp;
	ccs_mem_t    mem;
	logic        vec_req;
	logic [31:0] pc;
	logic        use_psp;
	logic        ack;
	logic        busy;
	int          n_mismatch = 0;
	int          checks = 0;
	int          cycles = 0;

	ccs_core_state dut (.mclk(mclk), .nrst(nrst), .req(req),
		.exc_req(exc_req), .exc_ret(exc_ret), .vec_valid(vec_valid),
		.vec_data(vec_data), .resp_reg(resp), .mem_reg(mem),
		.vec_req_reg(vec_req), .pc_reg(pc), .use_psp_reg(use_psp),
		.exc_ack_reg(ack), .busy_reg(busy));

	////////////////////////////////////////////////////////////////////
	// clock and hang guard, ceiling well above the full run
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_mismatch++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////
	// compares and closing report
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
		input string msg);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string msg);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	// drivers: one request cycle, then sample the answer cycle
	task automatic issue(input ccs_op_t op, input logic sf,
		input ccs_sreg_t sr, input ccs_size_t sz, input logic wr,
		input logic [4:0] cnt, input logic [31:0] a, input logic [31:0] b);
		ccs_req_t r;
		r = '{1'b1, op, sf, sr, sz, wr, cnt, a, b};
		@(posedge mclk);
		req <= r;
		@(posedge mclk);
		req.valid <= 1'b0;
		#1;
	endtask
	task automatic op2(input ccs_op_t op, input logic sf,
		input logic [31:0] a, input logic [31:0] b);
		issue(op, sf, SR_PSW, SZ_WORD, 1'b0, 5'h00, a, b);
	endtask
	task automatic spec(input ccs_op_t op, input ccs_sreg_t sr,
		input logic [31:0] b);
		issue(op, 1'b0, sr, SZ_WORD, 1'b0, 5'h00, 32'h0000_0000, b);
	endtask
	// exception entry or return pulse, ack looked at in its one cycle
	task automatic exc(input logic is_ret, input logic [5:0] num,
		input logic process_stack_pointer);
		ccs_exc_t e;
		e = '{1'b1, process_stack_pointer, num};
		@(posedge mclk);
		if (is_ret) begin
			exc_ret <= e;
		end else begin
			exc_req <= e;
		end
		@(posedge mclk);
		exc_ret.valid <= 1'b0;
		exc_req.valid <= 1'b0;
		#1;
	endtask
	task automatic do_reset(input logic [31:0] v);
		int i;
		@(posedge mclk);
		nrst <= 1'b0;
		repeat (5) @(posedge mclk);
		nrst <= 1'b1;
		for (i = 0; i < 20 && vec_req !== 1'b1; i++) begin
			@(posedge mclk);
			#1;
		end
		chk_bit(vec_req, 1'b1, "vector request");
		@(posedge mclk);
		vec_valid <= 1'b1;
		vec_data <= v;
		@(posedge mclk);
		vec_valid <= 1'b0;
		for (i = 0; i < 20 && busy !== 1'b0; i++) begin
			@(posedge mclk);
			#1;
		end
		chk_word(pc, v, "pc load");
		chk_bit(use_psp, 1'b0, "stack after reset");
	endtask

	////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_boot();
		spec(OP_SPEC_READ, SR_PSW, 32'h0000_0000);
		chk_word(resp.result & 32'h0fff_ffff, 32'h0100_0000, "psw");
		spec(OP_SPEC_READ, SR_CTRL, 32'h0000_0000);
		chk_bit(resp.result[1], 1'b0, "ctrl reset");
	endtask
	// flags move on the flag-setting variants and a status word write, not on a plain add
	task automatic t_flags();
		op2(OP_ADD, 1'b1, 32'h7fff_ffff, 32'h0000_0001);
		chk_word(resp.result, 32'h8000_0000, "add");
		spec(OP_SPEC_READ, SR_PSW, 32'h0000_0000);
		chk_word(resp.result, 32'h9100_0000, "add flags");
		op2(OP_ADD, 1'b0, 32'h0000_0000, 32'h0000_0000);
		spec(OP_SPEC_READ, SR_PSW, 32'h0000_0000);
		chk_word(resp.result, 32'h9100_0000, "plain add");
		op2(OP_SUB, 1'b1, 32'h0000_0005, 32'h0000_0005);
		spec(OP_SPEC_READ, SR_PSW, 32'h0000_0000);
		chk_word(resp.result, 32'h6100_0000, "sub flags");
		op2(OP_MOV, 1'b1, 32'h8000_0000, 32'h8000_0000);
		spec(OP_SPEC_READ, SR_PSW, 32'h0000_0000);
		chk_word(resp.result, 32'ha100_0000, "mov flags");
		spec(OP_SPEC_WRITE, SR_PSW, 32'hffff_ffff);
		spec(OP_SPEC_READ, SR_PSW, 32'h0000_0000);
		chk_word(resp.result, 32'hf100_0000, "reserved");
		op2(OP_ADD, 1'b1, 32'hffff_ffff, 32'h0000_0001);
		chk_word(resp.result, 32'h0000_0000, "zero sum");
		spec(OP_SPEC_READ, SR_PSW, 32'h0000_0000);
		chk_word(resp.result, 32'h6100_0000, "zero flags");
	endtask
	task automatic t_calc();
		op2(OP_MUL, 1'b0, 32'h0001_0000, 32'h0001_0001);
		chk_word(resp.result, 32'h0001_0000, "mul");
		chk_bit(resp.valid, 1'b1, "answer valid");
		op2(OP_REV_WORD, 1'b0, 32'h0000_0000, 32'h1122_3344);
		chk_word(resp.result, 32'h4433_2211, "rev");
		op2(OP_REV_HALVES, 1'b0, 32'h0000_0000, 32'h1122_3344);
		chk_word(resp.result, 32'h2211_4433, "rev halves");
		op2(OP_REV_SHALF, 1'b0, 32'h0000_0000, 32'h0000_1280);
		chk_word(resp.result, 32'hffff_8012, "rev shalf");
	endtask
	// zero lanes means the access must fault with no beat
	task automatic memop(input ccs_size_t sz, input logic [31:0] ad,
		input logic [31:0] b, input logic [3:0] l, input logic [31:0] w);
		issue(OP_MEM, 1'b0, SR_PSW, sz, 1'b1, 5'h00, ad, b);
		chk_bit(resp.fault, l == 4'h0, "align fault");
		chk_bit(mem.valid, l != 4'h0, "beat");
		if (l == 4'h0) begin
			exc(1'b1, EXC_THREAD, 1'b0);
		end else begin
			chk_word({28'h0, mem.lanes}, {28'h0, l}, "lanes");
			chk_word(mem.addr, ad, "beat addr");
			chk_bit(mem.write, 1'b1, "store beat");
			chk_word(mem.wdata, w, "lane data");
		end
	endtask
	task automatic t_mem();
		memop(SZ_WORD, 32'h2000_0001, 32'h1234_5678, 4'h0, 32'h0);
		memop(SZ_HALF, 32'h2000_0003, 32'h0000_abcd, 4'h0, 32'h0);
		memop(SZ_HALF, 32'h2000_0002, 32'h0000_abcd, 4'hc, 32'habcd_0000);
		memop(SZ_BYTE, 32'h2000_0003, 32'h0000_005a, 4'h8, 32'h5a00_0000);
		memop(SZ_WORD, 32'h2000_0004, 32'h1122_3344, 4'hf, 32'h1122_3344);
	endtask
	task automatic t_multi();
		int k;
		issue(OP_MULTI, 1'b0, SR_PSW, SZ_WORD, 1'b1, 5'h03,
			32'h2000_0010, 32'h0000_0000);
		chk_bit(busy, 1'b1, "busy in multi");
		for (k = 0; k < 3; k++) begin
			chk_bit(mem.valid, 1'b1, "multi beat");
			chk_word(mem.addr, 32'h2000_0010 + 4 * k, "multi addr");
			@(posedge mclk);
			#1;
		end
		chk_bit(mem.valid, 1'b0, "no fourth beat");
		chk_bit(busy, 1'b0, "busy after multi");
	endtask
	// stack choice: thread bit, barrier, handler override, return
	task automatic t_stack();
		spec(OP_SPEC_WRITE, SR_CTRL, 32'h0000_0002);
		chk_bit(use_psp, 1'b0, "before barrier");
		spec(OP_SYNC_BAR, SR_CTRL, 32'h0000_0000);
		chk_bit(use_psp, 1'b1, "after barrier");
		exc(1'b0, EXC_FIRST_EXT, 1'b0);
		chk_bit(ack, 1'b1, "entry ack");
		chk_bit(use_psp, 1'b0, "handler stack");
		exc(1'b1, EXC_THREAD, 1'b0);
		spec(OP_SPEC_READ, SR_CTRL, 32'h0000_0000);
		chk_bit(resp.result[1], 1'b0, "return ctrl");
		exc(1'b0, EXC_SVC, 1'b0);
		spec(OP_SPEC_WRITE, SR_CTRL, 32'h0000_0002);
		spec(OP_SYNC_BAR, SR_CTRL, 32'h0000_0000);
		chk_bit(use_psp, 1'b0, "handler main");
		spec(OP_SPEC_READ, SR_CTRL, 32'h0000_0000);
		chk_bit(resp.result[1], 1'b0, "ctrl write ignored");
		exc(1'b1, EXC_THREAD, 1'b1);
		chk_bit(use_psp, 1'b1, "return to process");
	endtask
	task automatic t_exc();
		logic [5:0] codes [4];
		int i;
		codes = '{EXC_SVC, EXC_PENDED_SERVICE_EXCEPTION, EXC_TICK, EXC_FIRST_EXT};
		spec(OP_CHG_STATE, SR_MASK, 32'h0000_0001);
		spec(OP_SPEC_READ, SR_MASK, 32'h0000_0000);
		chk_bit(resp.result[0], 1'b1, "mask set");
		exc(1'b0, EXC_TICK, 1'b0);
		chk_bit(ack, 1'b0, "masked");
		exc(1'b0, EXC_NMI, 1'b0);
		chk_bit(ack, 1'b1, "nmi taken");
		exc(1'b1, EXC_THREAD, 1'b0);
		spec(OP_SPEC_WRITE, SR_MASK, 32'h0000_0000);
		for (i = 0; i < 4; i++) begin
			exc(1'b0, codes[i], 1'b0);
			chk_bit(ack, 1'b1, "unmasked");
			spec(OP_SPEC_READ, SR_PSW, 32'h0000_0000);
			chk_word({26'h0, resp.result[5:0]}, {26'h0, codes[i]}, "num");
			exc(1'b1, EXC_THREAD, 1'b0);
		end
	endtask
	// process stack live, then a reboot with the state bit clear
	task automatic t_tstate();
		spec(OP_SPEC_WRITE, SR_CTRL, 32'h0000_0002);
		spec(OP_SYNC_BAR, SR_CTRL, 32'h0000_0000);
		chk_bit(use_psp, 1'b1, "process stack");
		do_reset(32'h0000_0100);
		op2(OP_ADD, 1'b1, 32'h0000_0001, 32'h0000_0001);
		chk_bit(resp.fault, 1'b1, "state bit clear");
		chk_bit(resp.valid, 1'b1, "fault answer");
	endtask

	////////////////////////////////////////////////////////////////////
	// main sequence, second boot with a cleared state bit
	initial begin
		nrst = 1'b0;
		req = '0;
		exc_req = '0;
		exc_ret = '0;
		vec_valid = 1'b0;
		vec_data = 32'h0000_0000;
		do_reset(32'h0000_0201);
		t_boot();
		t_flags();
		t_calc();
		t_mem();
		t_multi();
		t_stack();
		t_exc();
		t_tstate();
		print_verdict();
	end
endmodule // test_cpu_core_state_control
`default_nettype wire
